// ==== rtl/ldar_defs.svh ====
// ldar_defs.svh: register offsets, field positions, reset values, timing constants
// assumes: included by bare name from the package and the design modules
`ifndef LDAR_DEFS_SVH
`define LDAR_DEFS_SVH

// register word indices (the byte address is the index times four)
`define LDAR_IDX_RES0      6'h2A
`define LDAR_IDX_RES1      6'h2B
`define LDAR_IDX_RES2      6'h2C
`define LDAR_IDX_RES3      6'h2D
`define LDAR_IDX_DIFF01    6'h2E
`define LDAR_IDX_DIFF23    6'h2F
`define LDAR_IDX_CTRL1     6'h30
`define LDAR_IDX_LEDCUR    6'h31
`define LDAR_IDX_STATUS    6'h32
`define LDAR_ADDR_W        8

// first control register fields
`define LDAR_C1_TIMING_ENGINE_ENABLE    0
`define LDAR_C1_TX3SEL     1
`define LDAR_C1_LEDON      2
`define LDAR_C1_AVG_LO     8
`define LDAR_C1_AVG_HI     15
`define LDAR_C1_RESET      32'h0000_0001

// led current register fields
`define LDAR_LC_IR_LO      0
`define LDAR_LC_IR_HI      7
`define LDAR_LC_RED_LO     8
`define LDAR_LC_RED_HI     15
`define LDAR_LC_REF_LO     16
`define LDAR_LC_REF_HI     17
`define LDAR_LC_RESET      32'h0000_0000

// result layout
`define LDAR_RES_W         24
`define LDAR_CODE_W        22

// timing
`define LDAR_CLK_HZ        50000000
`define LDAR_CONV_NS       50000
`define LDAR_CONV_CYC      ((`LDAR_CONV_NS * (`LDAR_CLK_HZ / 1000000)) / 1000)
`define LDAR_PHASES        4

`endif

// ==== rtl/ldar_pkg.sv ====
// ldar_pkg.sv: types shared by the led drive and adc readout block
// assumes: ldar_defs.svh on the include path
package ldar_pkg;
    `include "ldar_defs.svh"

    typedef enum logic [1:0]
    {
        LDAR_ST_IDLE = 2'b00,
        LDAR_ST_WAIT = 2'b01,
        LDAR_ST_CONV = 2'b10
    } ldar_conv_state_t;

    typedef logic [`LDAR_RES_W-1:0] ldar_word_t;
endpackage : ldar_pkg

// ==== rtl/ldar_avg_if.sv ====
// ldar_avg_if.sv: carrier between the top module and the averaging unit
// assumes: one clock domain
`timescale 1ns/1ps
`include "ldar_defs.svh"
interface ldar_avg_if;
    logic                       sampleValid;
    logic [`LDAR_CODE_W-1:0]    sampleCode;
    logic                       phaseClear;
    logic [7:0]                 numAvg;
    logic [`LDAR_RES_W-1:0]     avgValue;

    modport top
    (
        output sampleValid, sampleCode, phaseClear, numAvg,
        input  avgValue
    );
    modport avg
    (
        input  sampleValid, sampleCode, phaseClear, numAvg,
        output avgValue
    );
endinterface : ldar_avg_if

// ==== rtl/ldar_avg.sv ====
// ldar_avg.sv: averaging unit, accumulates signed codes of one phase
// assumes: phaseClear pulses at each phase boundary, same clock as the top
`timescale 1ns/1ps
`include "ldar_defs.svh"
module ldar_avg
    import ldar_pkg::*;
(
    input wire logic    clk,
    input wire logic    resetn,
    ldar_avg_if.avg     bus
);
    logic signed [31:0] acc_r;
    logic        [8:0]  cnt_r;
    logic signed [31:0] accNxt;
    logic signed [31:0] quot;

    assign accNxt = acc_r + {{10{bus.sampleCode[`LDAR_CODE_W-1]}}, bus.sampleCode};
    assign quot   = (cnt_r == 9'h000) ? 32'sh0 : acc_r / $signed({23'h0, cnt_r});
    // sign-extend the 22-bit average to the full 24-bit word
    assign bus.avgValue = quot[`LDAR_RES_W-1:0];

    // ----------------------------------------------------------------
    // accumulation
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn || bus.phaseClear)
        begin
            acc_r <= 32'sh0;
            cnt_r <= 9'h000;
        end
        else if (bus.sampleValid && cnt_r <= {1'b0, bus.numAvg})
        begin
            acc_r <= accNxt;
            cnt_r <= cnt_r + 9'h001;
        end
    end

    a_avg_count_bound: assert property (@(posedge clk) disable iff (!resetn)
        cnt_r <= {1'b0, bus.numAvg} + 9'h001 || $past(bus.numAvg) != bus.numAvg)
        else $error("average count ran past its limit");
endmodule : ldar_avg

// ==== rtl/ldar_top.sv ====
// ldar_top.sv: led drive steering and adc readout with avalon-mm registers
// assumes: adc reset pulse and phase strobes come from the timing engine,
// adcCode is a 22-bit code from the converter on this clock
//
// Functional notes
// - Third-led select moves positive drive control to third led pin.
// - With third-led select, positive-pin diagnostics report the third pin.
// - Led drive-on stays inactive throughout every ambient phase; ledDriveOn is registered, so it drops one clock after ambientPhase rises.
// - Conversion starts only after adc reset falling edge.
// - Each conversion lasts 50 us.
// - Samples of a phase pass through an averaging unit.
// - Results are 24 bits; code in bits 21..0, upper bits 23..22 carry its sign extension.
// - Led current set by an 8-bit code tracking the reference.
// - Red and infrared current references are independent; here both share the one txRefSel field (bits 17..16).
// - Red is second led phase, infrared the first.
// - Transmit reference programmable from 0.25 V to 1 V.
// - Each adc reset rising edge seen during a conversion writes next result register in sequence.
// - Result pair updates refresh their difference register.
// - Codes are two's complement, msb first.
`timescale 1ns/1ps
`include "ldar_defs.svh"
module ldar_top
    import ldar_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [`LDAR_ADDR_W-1:0]    address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [31:0]                writedata,
    output logic      [31:0]                readdata,
    output logic                            waitrequest,
    input  wire logic                       adcReset,
    input  wire logic                       ambientPhase,
    input  wire logic                       ledPhaseSecond,
    input  wire logic                       ledDrive,
    input  wire logic [`LDAR_CODE_W-1:0]    adcCode,
    input  wire logic                       diagPosFault,
    input  wire logic                       diagNegFault,
    input  wire logic                       diagThirdFault,
    output logic                            ledDrivePosPin,
    output logic                            ledDriveNegPin,
    output logic                            thirdLedPin,
    output logic                            ledDriveOn,
    output logic      [7:0]                 ledCurrentCode,
    output logic      [1:0]                 txRefSel,
    output logic                            timingEngineEnable
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0]            ctrl1_r;
    logic [31:0]            ledCur_r;
    ldar_word_t             res_r [`LDAR_PHASES];
    ldar_word_t             diff01_r;
    ldar_word_t             diff23_r;
    logic [1:0]             slot_r;
    logic                   rstDly_r;
    ldar_conv_state_t       state_r;
    ldar_conv_state_t       stateNxt;
    logic [15:0]            convCnt_r;
    logic                   sampleValid_r;
    logic                   diagPos_r;
    logic                   diagNeg_r;
    logic                   ackPend_r;
    logic                   wrPend_r;
    wire  [2:0]             diagClean;

    ldar_avg_if avgBus();

    function automatic logic [5:0] regIndex(input logic [`LDAR_ADDR_W-1:0] a);
        regIndex = a[7:2];
    endfunction : regIndex

    function automatic ldar_word_t diffOf(input ldar_word_t a, input ldar_word_t b);
        diffOf = a - b;
    endfunction : diffOf

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire [5:0]  idx        = regIndex(address);
    wire        thirdSel   = ctrl1_r[`LDAR_C1_TX3SEL];
    wire        timing_engine_enable    = ctrl1_r[`LDAR_C1_TIMING_ENGINE_ENABLE];
    wire        ledOnCtl   = ctrl1_r[`LDAR_C1_LEDON];
    wire [7:0]  numAvg     = ctrl1_r[`LDAR_C1_AVG_HI:`LDAR_C1_AVG_LO];
    wire [7:0]  irCode     = ledCur_r[`LDAR_LC_IR_HI:`LDAR_LC_IR_LO];
    wire [7:0]  redCode    = ledCur_r[`LDAR_LC_RED_HI:`LDAR_LC_RED_LO];
    wire        rstRise    = adcReset && !rstDly_r;
    wire        rstFall    = !adcReset && rstDly_r;
    wire        convDone   = (state_r == LDAR_ST_CONV) &&
                             (convCnt_r == 16'(`LDAR_CONV_CYC - 1));
    wire        busReq     = (read || write) && !ackPend_r;
    // a write lands at the edge that sees waitrequest low
    wire        wrTake     = wrPend_r && write;
    wire [1:0]  slotPrev   = slot_r;
    wire        posDrive   = timing_engine_enable && ledDrive && ledPhaseSecond && !thirdSel;
    wire        thirdDrive = timing_engine_enable && ledDrive && ledPhaseSecond && thirdSel;
    wire        negDrive   = timing_engine_enable && ledDrive && !ledPhaseSecond;
    wire        driveOnNxt = ledOnCtl && timing_engine_enable && !ambientPhase;
    wire [7:0]  curNxt     = ledPhaseSecond ? redCode : irCode;
    wire        diagPosNxt = thirdSel ? diagClean[2] : diagClean[0];
    wire [31:0] statusWord = {29'h0, diagNeg_r, diagPos_r, thirdSel};

    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = 32'h0000_0000;
        case (idx)
            `LDAR_IDX_RES0:   rdMux = {8'h00, res_r[0]};
            `LDAR_IDX_RES1:   rdMux = {8'h00, res_r[1]};
            `LDAR_IDX_RES2:   rdMux = {8'h00, res_r[2]};
            `LDAR_IDX_RES3:   rdMux = {8'h00, res_r[3]};
            `LDAR_IDX_DIFF01: rdMux = {8'h00, diff01_r};
            `LDAR_IDX_DIFF23: rdMux = {8'h00, diff23_r};
            `LDAR_IDX_CTRL1:  rdMux = ctrl1_r;
            `LDAR_IDX_LEDCUR: rdMux = ledCur_r;
            `LDAR_IDX_STATUS: rdMux = statusWord;
            default:          rdMux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // fault input capture
    // ----------------------------------------------------------------
    wire [2:0]  diagPins   = {diagThirdFault, diagNegFault, diagPosFault};

    // a level change counts once the second and third stages agree
    for (genvar g = 0; g < 3; g++)
    begin : g_diag_sync
        logic meta_r;
        logic sync_r;
        logic late_r;
        logic clean_r;

        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                meta_r  <= 1'b0;
                sync_r  <= 1'b0;
                late_r  <= 1'b0;
                clean_r <= 1'b0;
            end
            else
            begin
                meta_r  <= diagPins[g];
                sync_r  <= meta_r;
                late_r  <= sync_r;
                if (sync_r == late_r)
                    clean_r <= late_r;
            end
        end

        assign diagClean[g] = clean_r;
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            LDAR_ST_IDLE: if (rstRise) stateNxt = LDAR_ST_WAIT;
            LDAR_ST_WAIT: if (rstFall) stateNxt = LDAR_ST_CONV;
            LDAR_ST_CONV: if (rstRise) stateNxt = LDAR_ST_WAIT;
            default:      stateNxt = LDAR_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r       <= LDAR_ST_IDLE;
            convCnt_r     <= 16'h0000;
            rstDly_r      <= 1'b0;
            sampleValid_r <= 1'b0;
        end
        else
        begin
            state_r       <= stateNxt;
            rstDly_r      <= adcReset;
            sampleValid_r <= convDone;
            if (state_r != LDAR_ST_CONV || convDone)
                convCnt_r <= 16'h0000;
            else
                convCnt_r <= convCnt_r + 16'h0001;
        end
    end

    assign avgBus.sampleValid = sampleValid_r;
    assign avgBus.sampleCode  = adcCode;
    assign avgBus.phaseClear  = rstRise;
    assign avgBus.numAvg      = numAvg;

    ldar_avg u_avg
    (
        .clk    (clk),
        .resetn (resetn),
        .bus    (avgBus.avg)
    );

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < `LDAR_PHASES; i++)
                res_r[i] <= '0;
            diff01_r <= '0;
            diff23_r <= '0;
            slot_r   <= 2'h0;
        end
        else if (rstRise && state_r == LDAR_ST_CONV)
        begin
            res_r[slotPrev] <= avgBus.avgValue;
            slot_r          <= slot_r + 2'h1;
            if (slotPrev == 2'h0)
                diff01_r <= diffOf(avgBus.avgValue, res_r[1]);
            else if (slotPrev == 2'h1)
                diff01_r <= diffOf(res_r[0], avgBus.avgValue);
            else if (slotPrev == 2'h2)
                diff23_r <= diffOf(avgBus.avgValue, res_r[3]);
            else
                diff23_r <= diffOf(res_r[2], avgBus.avgValue);
        end
    end

    // ----------------------------------------------------------------
    // avalon-mm slave: one wait cycle, answer on the second
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ackPend_r   <= 1'b0;
            wrPend_r    <= 1'b0;
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
            ctrl1_r     <= `LDAR_C1_RESET;
            ledCur_r    <= `LDAR_LC_RESET;
        end
        else
        begin
            ackPend_r   <= busReq;
            waitrequest <= !busReq;
            readdata    <= read ? rdMux : 32'h0000_0000;
            wrPend_r    <= busReq && write;
            if (wrTake && idx == `LDAR_IDX_CTRL1)
                ctrl1_r <= writedata;
            if (wrTake && idx == `LDAR_IDX_LEDCUR)
                ledCur_r <= writedata;
        end
    end

    // ----------------------------------------------------------------
    // led drive outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ledDrivePosPin     <= 1'b0;
            ledDriveNegPin     <= 1'b0;
            thirdLedPin        <= 1'b0;
            ledDriveOn         <= 1'b0;
            ledCurrentCode     <= 8'h00;
            txRefSel           <= 2'h0;
            timingEngineEnable <= 1'b0;
            diagPos_r          <= 1'b0;
            diagNeg_r          <= 1'b0;
        end
        else
        begin
            ledDrivePosPin     <= posDrive;
            ledDriveNegPin     <= negDrive;
            thirdLedPin        <= thirdDrive;
            ledDriveOn         <= driveOnNxt;
            ledCurrentCode     <= curNxt;
            txRefSel           <= ledCur_r[`LDAR_LC_REF_HI:`LDAR_LC_REF_LO];
            timingEngineEnable <= timing_engine_enable;
            diagPos_r          <= diagPosNxt;
            diagNeg_r          <= diagClean[1];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_ambient_drive_off: assert property (@(posedge clk) disable iff (!resetn)
        ambientPhase |=> !ledDriveOn)
        else $error("drive-on active in ambient phase");
    a_third_steer_pos: assert property (@(posedge clk) disable iff (!resetn)
        thirdSel |=> !ledDrivePosPin)
        else $error("positive pin driven in third-led mode");
    a_third_steer_on: assert property (@(posedge clk) disable iff (!resetn)
        (thirdSel && timing_engine_enable && ledDrive && ledPhaseSecond) |=> thirdLedPin)
        else $error("third pin not driven");
    a_diag_route: assert property (@(posedge clk) disable iff (!resetn)
        (thirdSel && diagClean[2]) |=> diagPos_r)
        else $error("third-led diagnostic not reported");
    a_conv_after_fall: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(state_r == LDAR_ST_CONV)) |-> $past(rstFall))
        else $error("conversion began without reset falling edge");
    a_conv_length: assert property (@(posedge clk) disable iff (!resetn)
        convCnt_r <= 16'(`LDAR_CONV_CYC - 1))
        else $error("conversion counter ran past its length");
    a_slot_advance: assert property (@(posedge clk) disable iff (!resetn)
        (rstRise && state_r == LDAR_ST_CONV) |=> slot_r == $past(slot_r) + 2'h1)
        else $error("result slot did not advance");
    a_diff_pair: assert property (@(posedge clk) disable iff (!resetn)
        (rstRise && state_r == LDAR_ST_CONV && slot_r == 2'h1)
        |=> diff01_r == res_r[0] - res_r[1])
        else $error("difference register stale");
    a_cur_select: assert property (@(posedge clk) disable iff (!resetn)
        ledPhaseSecond |=> ledCurrentCode == $past(redCode))
        else $error("red code not used in second phase");
endmodule : ldar_top

// ==== dv/ldar_sensor_model.sv ====
// ldar_sensor_model.sv: leds and photodiode as seen through the converter
// assumes: drive pins and fault settings on the design clock
`timescale 1ns/1ps
module ldar_sensor_model
#(
    parameter logic [21:0] NEG_CODE   = 22'h0012AB,
    parameter logic [21:0] POS_CODE   = 22'h00340F,
    parameter logic [21:0] THIRD_CODE = 22'h1FFFFF,
    parameter logic [21:0] DARK_CODE  = 22'h3FFF00
)
(
    input  wire logic           clk,
    input  wire logic           posPin,
    input  wire logic           negPin,
    input  wire logic           thirdPin,
    input  wire logic [2:0]     faultSet,
    output logic      [21:0]    adcCode,
    output logic                diagPosFault,
    output logic                diagNegFault,
    output logic                diagThirdFault
);
    // ------------------------------------------------------------
    // light reaching the photodiode
    // ------------------------------------------------------------
    wire logic [21:0] lightCode = negPin ? NEG_CODE :
                                  posPin ? POS_CODE :
                                  thirdPin ? THIRD_CODE : DARK_CODE;
    // signed 22-bit code, one cycle behind the light
    always @(posedge clk)
        adcCode <= lightCode;
    assign diagPosFault   = faultSet[0];
    assign diagNegFault   = faultSet[1];
    assign diagThirdFault = faultSet[2];
endmodule : ldar_sensor_model

// ==== dv/testbench.sv ====
// testbench.sv: self-checking bench for the led drive and adc readout block
// assumes: ldar_pkg, ldar_top and ldar_sensor_model compiled before it
`timescale 1ns/1ps
`include "ldar_defs.svh"
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module testbench;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam logic [21:0] NEG_C = 22'h0012AB, POS_C = 22'h00340F;
    localparam logic [21:0] THR_C = 22'h1FFFFF, DRK_C = 22'h3FFF00;
    localparam logic [7:0]  A_RES0 = {`LDAR_IDX_RES0, 2'b00};
    localparam logic [7:0]  A_CTRL = {`LDAR_IDX_CTRL1, 2'b00};
    localparam logic [7:0]  A_CUR  = {`LDAR_IDX_LEDCUR, 2'b00};
    localparam logic [7:0]  A_STAT = {`LDAR_IDX_STATUS, 2'b00};
    localparam int          PHASE_CYC = 2700;
    typedef struct packed
    {
        logic [31:0] ctrl;
        logic        second;
        logic        amb;
        logic        drive;
        logic [4:0]  exp;
    } ldar_row_t;
    // exp = {pos, neg, third, drive on, timing enable}
    localparam ldar_row_t ROWS [7] = '{
        '{32'h5, 1'b0, 1'b0, 1'b1, 5'b01011}, '{32'h5, 1'b1, 1'b0, 1'b1, 5'b10011},
        '{32'h7, 1'b1, 1'b0, 1'b1, 5'b00111}, '{32'h7, 1'b0, 1'b0, 1'b1, 5'b01011},
        '{32'h5, 1'b0, 1'b1, 1'b0, 5'b00001}, '{32'h4, 1'b0, 1'b0, 1'b0, 5'b00000},
        '{32'h1, 1'b1, 1'b0, 1'b0, 5'b00001}};
    logic        clk = 1'b0;
    logic        resetn, read, write, waitrequest, adcReset, ambientPhase;
    logic        ledPhaseSecond, ledDrive, diagPosFault, diagNegFault, diagThirdFault;
    logic        ledDrivePosPin, ledDriveNegPin, thirdLedPin, ledDriveOn, timingEngineEnable;
    logic [7:0]  address, ledCurrentCode;
    logic [31:0] writedata, readdata, rdData;
    logic [21:0] adcCode;
    logic [1:0]  txRefSel;
    logic [2:0]  faultSet;
    logic [23:0] expRes [4];
    int          n_mismatch = 0;
    int          checked = 0;

    always #10 clk = ~clk;

    ldar_top dut_u (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .adcReset(adcReset), .ambientPhase(ambientPhase),
        .ledPhaseSecond(ledPhaseSecond), .ledDrive(ledDrive), .adcCode(adcCode),
        .diagPosFault(diagPosFault), .diagNegFault(diagNegFault),
        .diagThirdFault(diagThirdFault), .ledDrivePosPin(ledDrivePosPin),
        .ledDriveNegPin(ledDriveNegPin), .thirdLedPin(thirdLedPin),
        .ledDriveOn(ledDriveOn), .ledCurrentCode(ledCurrentCode), .txRefSel(txRefSel),
        .timingEngineEnable(timingEngineEnable));
    ldar_sensor_model #(.NEG_CODE(NEG_C), .POS_CODE(POS_C), .THIRD_CODE(THR_C),
        .DARK_CODE(DRK_C)) sensor_u (.clk(clk), .posPin(ledDrivePosPin),
        .negPin(ledDriveNegPin), .thirdPin(thirdLedPin), .faultSet(faultSet),
        .adcCode(adcCode), .diagPosFault(diagPosFault), .diagNegFault(diagNegFault),
        .diagThirdFault(diagThirdFault));

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task automatic bus_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rdData = readdata;
        read   <= 1'b0;
        write  <= 1'b0;
        @(posedge clk);
    endtask : bus_access

    task automatic adc_phase(input logic lit, input logic second, input int len);
        adcReset       <= 1'b1;
        ambientPhase   <= !lit;
        ledPhaseSecond <= second;
        ledDrive       <= lit;
        repeat (6) @(posedge clk);
        adcReset <= 1'b0;
        repeat (len - 6) @(posedge clk);
    endtask : adc_phase

    function automatic logic [23:0] sx(input logic [21:0] c);
        return {{2{c[21]}}, c};
    endfunction : sx

    // one frame of four phases; select stays clear, model codes are settled
    task automatic adc_frame(input logic [31:0] ctrl, input int len);
        bus_access(1'b1, A_CTRL, ctrl);
        adc_phase(1'b1, 1'b0, len);
        adc_phase(1'b0, 1'b0, len);
        adc_phase(1'b1, 1'b1, len);
        adc_phase(1'b0, 1'b1, len);
        adcReset <= 1'b1;
        repeat (6) @(posedge clk);
        adcReset <= 1'b0;
        repeat (10) @(posedge clk);
        expRes = '{sx(NEG_C), sx(DRK_C), sx(POS_C), sx(DRK_C)};
        for (int s = 0; s < 4; s++)
        begin
            bus_access(1'b0, A_RES0 + 8'(4 * s), 32'h0);
            `CHK("result slot", expRes[s], rdData[23:0])
        end
        bus_access(1'b0, A_RES0 + 8'h10, 32'h0);
        `CHK("diff01", expRes[0] - expRes[1], rdData[23:0])
        bus_access(1'b0, A_RES0 + 8'h14, 32'h0);
        `CHK("diff23", expRes[2] - expRes[3], rdData[23:0])
        bus_access(1'b1, A_RES0, 32'hFFFF_FFFF);
        bus_access(1'b0, A_RES0, 32'h0);
        `CHK("result read only", expRes[0], rdData[23:0])
        $display("test adc frame done");
    endtask : adc_frame

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        resetn = 1'b0; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
        adcReset = 1'b0; ambientPhase = 1'b0; ledPhaseSecond = 1'b0; ledDrive = 1'b0;
        faultSet = 3'b000;
        repeat (16) @(posedge clk);
        `CHK("waitrequest in reset", 1'b1, waitrequest)
        `CHK("drive on in reset", 1'b0, ledDriveOn)
        resetn <= 1'b1;
        @(posedge clk);
        bus_access(1'b0, A_CTRL, 32'h0);
        `CHK("ctrl reset", `LDAR_C1_RESET, rdData)
        bus_access(1'b0, A_CUR, 32'h0);
        `CHK("led current reset", `LDAR_LC_RESET, rdData)
        bus_access(1'b1, 8'h04, 32'hFFFF_FFFF);
        bus_access(1'b0, 8'h04, 32'h0);
        `CHK("unmapped read", 32'h0, rdData)
        $display("test reset and map done");
        for (int i = 0; i < 7; i++)
        begin
            bus_access(1'b1, A_CTRL, ROWS[i].ctrl);
            ledPhaseSecond <= ROWS[i].second;
            ambientPhase   <= ROWS[i].amb;
            ledDrive       <= ROWS[i].drive;
            repeat (3) @(posedge clk);
            `CHK("pins", ROWS[i].exp, {ledDrivePosPin, ledDriveNegPin, thirdLedPin, ledDriveOn, timingEngineEnable})
        end
        $display("test steering rows done");
        for (int r = 0; r < 4; r++)
        begin
            bus_access(1'b1, A_CUR, {14'h0, r[1:0], 8'hC0 + 8'(r), 8'h0F + 8'(r)});
            ledPhaseSecond <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("ir code", 8'h0F + 8'(r), ledCurrentCode)
            `CHK("tx reference", r[1:0], txRefSel)
            ledPhaseSecond <= 1'b1;
            repeat (3) @(posedge clk);
            `CHK("red code", 8'hC0 + 8'(r), ledCurrentCode)
        end
        $display("test current codes done");
        faultSet <= 3'b001;
        repeat (6) @(posedge clk);
        bus_access(1'b1, A_CTRL, 32'h5);
        bus_access(1'b0, A_STAT, 32'h0);
        `CHK("status pos fault", 3'b010, rdData[2:0])
        bus_access(1'b1, A_CTRL, 32'h7);
        bus_access(1'b0, A_STAT, 32'h0);
        `CHK("status third clean", 3'b001, rdData[2:0])
        faultSet <= 3'b110;
        repeat (6) @(posedge clk);
        bus_access(1'b0, A_STAT, 32'h0);
        `CHK("status third fault", 3'b111, rdData[2:0])
        faultSet <= 3'b000;
        $display("test diagnostics done");
        adc_frame(32'h0000_0005, PHASE_CYC);
        bus_access(1'b1, A_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("idle outputs", 2'b00, {ledDriveOn, timingEngineEnable})
        $display("test inactivity done");
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("waitrequest in mid reset", 1'b1, waitrequest)
        resetn <= 1'b1;
        @(posedge clk);
        bus_access(1'b0, A_CTRL, 32'h0);
        `CHK("ctrl after mid reset", `LDAR_C1_RESET, rdData)
        bus_access(1'b0, A_RES0, 32'h0);
        `CHK("result after mid reset", 24'h000000, rdData[23:0])
        $display("test mid-run reset done");
        // two conversions per phase, averaged
        adc_frame(32'h0000_0105, 2 * PHASE_CYC);
        wrap_up();
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        $display("ERROR watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule : testbench
